// ==== core/bwc_pkg.sv ====
package bwc_pkg;
  localparam int BP_PAIRS = 6;
  localparam int WP_PAIRS = 4;
  localparam logic [5:0] BP_CTX_AWARE = 6'h30;
  localparam int EN_BIT = 0;
  localparam int PRIV_LO = 1;
  localparam int KIND_LO = 3;
  localparam int HIGHER_BIT = 13;
  localparam int SEC_LO = 14;
  localparam int LINKIDX_LO = 16;
  localparam int MTYPE_LO = 20;
  localparam int LINK_BIT = 20;
  localparam int MASK_LO = 24;
  localparam logic [31:0] BP_KEEP = 32'h00bfe1e7;
  localparam logic [31:0] BP_BASE_BITS = 32'h00a00000;
  localparam logic [31:0] WP_KEEP = 32'h1f1fffff;
  localparam logic [4:0] MASK_MIN = 5'h03;
  localparam logic [1:0] SEC_NONSEC = 2'h1;
  localparam logic [1:0] SEC_SECURE = 2'h2;
  localparam logic [1:0] EL_USER = 2'h0;
  localparam logic [1:0] EL_KERNEL = 2'h1;
  localparam logic [1:0] EL_HYP = 2'h2;
  localparam logic [11:0] OFF_DBG_CTRL = 12'h020;
  localparam logic [11:0] OFF_CLAIM_SET = 12'hfa0;
  localparam logic [11:0] OFF_CLAIM_CLR = 12'hfa4;
  localparam logic [3:0] BP_PAGE = 4'h4;
  localparam logic [3:0] WP_PAGE = 4'h8;
  localparam logic [3:0] SLOT_VLO = 4'h0;
  localparam logic [3:0] SLOT_VHI = 4'h4;
  localparam logic [3:0] SLOT_CTRL = 4'h8;
  localparam logic [7:0] CLAIM_IMPL = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MT_ADDR = 4'h0, MT_ADDR_L = 4'h1, MT_CID = 4'h2, MT_CID_L = 4'h3,
    MT_MISS = 4'h4, MT_MISS_L = 4'h5, MT_OSCTX = 4'h6, MT_OSCTX_L = 4'h7,
    MT_VM = 4'h8, MT_VM_L = 4'h9, MT_VMCID = 4'ha, MT_VMCID_L = 4'hb,
    MT_HYPCTX = 4'hc, MT_HYPCTX_L = 4'hd, MT_FULL = 4'he, MT_FULL_L = 4'hf
  } bwc_mtype_e;

  typedef enum logic [7:0] {
    RG_NONE = 8'h01, RG_DBG = 8'h02, RG_BPV = 8'h04, RG_BPC = 8'h08,
    RG_WPV = 8'h10, RG_WPC = 8'h20, RG_CSET = 8'h40, RG_CCLR = 8'h80
  } bwc_region_e;

  typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} bwc_wstate_e;
  typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} bwc_rstate_e;

  typedef struct packed {
    bwc_region_e rg;
    logic [2:0] idx;
    logic hi;
  } bwc_dec_s;
endpackage

// ==== core/bwc_qual.sv ====
module bwc_qual
  import bwc_pkg::*;
(
  input wire logic [31:0] ctrl,
  input wire logic curSecure,
  input wire logic [1:0] curEl,
  output logic permit
);
  always_comb begin
    logic secOk;
    logic elOk;
    secOk = 1'b1;
    elOk = 1'b0;
    if (ctrl[SEC_LO+:2] == SEC_NONSEC) begin
      secOk = !curSecure;
    end else if (ctrl[SEC_LO+:2] == SEC_SECURE) begin
      secOk = curSecure;
    end
    // in hyp mode the privilege bits carry no weight, only the higher-level bit
    unique case (curEl)
      EL_USER: elOk = ctrl[PRIV_LO+1];
      EL_KERNEL: elOk = ctrl[PRIV_LO];
      EL_HYP: elOk = ctrl[HIGHER_BIT];
      default: elOk = 1'b0;
    endcase
    permit = secOk & elOk;
  end
endmodule

// ==== core/bwc_top.sv ====
// Summary of operation
// - four-bit match type decodes sixteen codes
// - base bits zero unless breakpoint context-aware
// - linked index selects context breakpoint; mismatch zero
// - security, higher, privilege fields gate breakpoints
// - privilege bits ignored in hyp mode
// - enable bit zero never arms breakpoint
// - claim set writes ones, zeros ignored
// - four watchpoint pairs, control plus value
// - mask zero none, one/two reserved, else mask
// - link bit chooses linked watchpoint, index used
// - security, higher, privilege fields gate watchpoints
// - byte lane select picks watched bytes
// - access kind: load, store, both
// - reserved access kind acts as disabled
// - enable zero disables, access kind ignored
// - control fields need no cold-reset value
// - six breakpoint pairs, control plus value
// - match type at bits 23:20
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module bwc_top
  import bwc_pkg::*;
#(
  parameter int NUM_BP = BP_PAIRS,
  parameter int NUM_WP = WP_PAIRS,
  parameter logic [NUM_BP-1:0] CTX_AWARE = BP_CTX_AWARE
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic curSecure,
  input wire logic [1:0] curEl,
  output logic [NUM_BP-1:0] bpArmed,
  output logic [NUM_BP-1:0] bpLinked,
  output logic [NUM_BP-1:0] bpCtxMatch,
  output logic [4*NUM_BP-1:0] bpLinkIdx,
  output logic [NUM_WP-1:0] wpArmed,
  output logic [NUM_WP-1:0] wpLoadArm,
  output logic [NUM_WP-1:0] wpStoreArm,
  output logic [NUM_WP-1:0] wpLinked,
  output logic [4*NUM_WP-1:0] wpLinkIdx,
  output logic [7:0] claimTags
);
  typedef struct packed {
    bwc_wstate_e wstate;
    bwc_rstate_e rstate;
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic dbgEn;
    logic [7:0] claim;
    logic [NUM_BP-1:0][31:0] bpCtrl;
    logic [NUM_BP-1:0][1:0][31:0] bpVal;
    logic [NUM_WP-1:0][31:0] wpCtrl;
    logic [NUM_WP-1:0][1:0][31:0] wpVal;
    logic [NUM_BP-1:0] bpArmed;
    logic [NUM_BP-1:0] bpLinked;
    logic [NUM_BP-1:0] bpCtxMatch;
    logic [4*NUM_BP-1:0] bpLinkIdx;
    logic [NUM_WP-1:0] wpArmed;
    logic [NUM_WP-1:0] wpLoadArm;
    logic [NUM_WP-1:0] wpStoreArm;
    logic [NUM_WP-1:0] wpLinked;
    logic [4*NUM_WP-1:0] wpLinkIdx;
  } bwc_state_s;

  bwc_state_s st_r;
  bwc_state_s st_nxt;
  logic [NUM_BP-1:0] bpPermit;
  logic [NUM_WP-1:0] wpPermit;
  logic [NUM_BP-1:0] bpEnVec;
  logic [NUM_BP-1:0] bpRsvd;
  logic [NUM_WP-1:0] wpEnVec;
  logic [NUM_WP-1:0] wpRsvd;
  logic [NUM_WP-1:0] kindZero;
  logic [NUM_WP-1:0] maskRsvd;
  logic wrFire;
  bwc_dec_s wrDec;
  logic [7:0] claimSetMask;
  logic [7:0] claimClrMask;

  function automatic bwc_dec_s decodeAddr(input logic [11:0] a);
    bwc_dec_s d;
    d.rg = RG_NONE;
    d.idx = a[6:4];
    d.hi = (a[3:0] == SLOT_VHI);
    if (a == OFF_DBG_CTRL) begin
      d.rg = RG_DBG;
    end else if (a == OFF_CLAIM_SET) begin
      d.rg = RG_CSET;
    end else if (a == OFF_CLAIM_CLR) begin
      d.rg = RG_CCLR;
    end else if (a[11:8] == BP_PAGE && a[7:4] < 4'(NUM_BP)) begin
      if (a[3:0] == SLOT_CTRL) begin
        d.rg = RG_BPC;
      end else if (a[3:0] == SLOT_VLO || d.hi) begin
        d.rg = RG_BPV;
      end
    end else if (a[11:8] == WP_PAGE && a[7:4] < 4'(NUM_WP)) begin
      if (a[3:0] == SLOT_CTRL) begin
        d.rg = RG_WPC;
      end else if (a[3:0] == SLOT_VLO || d.hi) begin
        d.rg = RG_WPV;
      end
    end
    return d;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic isContext(input bwc_mtype_e t);
    logic c;
    unique case (t)
      MT_ADDR, MT_ADDR_L, MT_MISS, MT_MISS_L: c = 1'b0;
      MT_CID, MT_CID_L, MT_OSCTX, MT_OSCTX_L, MT_VM, MT_VM_L, MT_VMCID, MT_VMCID_L,
      MT_HYPCTX, MT_HYPCTX_L, MT_FULL, MT_FULL_L: c = 1'b1;
    endcase
    return c;
  endfunction

  for (genvar g = 0; g < NUM_BP; g++) begin : gBp
    bwc_qual uQual (.ctrl(st_r.bpCtrl[g]), .curSecure(curSecure), .curEl(curEl),
                    .permit(bpPermit[g]));
    assign bpEnVec[g] = st_r.bpCtrl[g][EN_BIT];
    assign bpRsvd[g] = |(st_r.bpCtrl[g] & ~BP_KEEP);
  end
  for (genvar g = 0; g < NUM_WP; g++) begin : gWp
    bwc_qual uQual (.ctrl(st_r.wpCtrl[g]), .curSecure(curSecure), .curEl(curEl),
                    .permit(wpPermit[g]));
    assign wpEnVec[g] = st_r.wpCtrl[g][EN_BIT];
    assign wpRsvd[g] = |(st_r.wpCtrl[g] & ~WP_KEEP);
    assign kindZero[g] = (st_r.wpCtrl[g][KIND_LO+:2] == 2'b00);
    assign maskRsvd[g] = (st_r.wpCtrl[g][MASK_LO+:5] != 5'h00)
                         && (st_r.wpCtrl[g][MASK_LO+:5] < MASK_MIN);
  end

  assign wrDec = decodeAddr(st_r.awAddr);
  assign wrFire = (st_r.wstate == WS_COLLECT) && st_r.awHeld && st_r.wHeld;
  assign claimSetMask = (wrFire && wrDec.rg == RG_CSET && st_r.wStrb[0]) ? st_r.wData[7:0] : '0;
  assign claimClrMask = (wrFire && wrDec.rg == RG_CCLR && st_r.wStrb[0]) ? st_r.wData[7:0] : '0;

  always_comb begin
    bwc_dec_s rd;
    logic [31:0] wv;
    rd = decodeAddr(araddr);
    wv = '0;
    st_nxt = st_r;
    // write side: address and data are latched independently, in any order
    if (awvalid && st_r.awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wdata;
      st_nxt.wStrb = wstrb;
    end
    unique case (st_r.wstate)
      WS_COLLECT: begin
        if (wrFire) begin
          st_nxt.awHeld = 1'b0;
          st_nxt.wHeld = 1'b0;
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp = (wrDec.rg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
          st_nxt.wstate = WS_RESP;
          unique case (wrDec.rg)
            RG_DBG: st_nxt.dbgEn = st_r.wStrb[0] ? st_r.wData[0] : st_r.dbgEn;
            RG_CSET: st_nxt.claim = st_r.claim | claimSetMask;
            RG_CCLR: st_nxt.claim = st_r.claim & ~claimClrMask;
            RG_BPC: begin
              wv = mergeBytes(st_r.bpCtrl[wrDec.idx], st_r.wData, st_r.wStrb);
              wv = wv & BP_KEEP;
              if (!CTX_AWARE[wrDec.idx]) begin
                wv = wv & ~BP_BASE_BITS;
              end
              st_nxt.bpCtrl[wrDec.idx] = wv;
            end
            RG_BPV: st_nxt.bpVal[wrDec.idx][wrDec.hi] =
              mergeBytes(st_r.bpVal[wrDec.idx][wrDec.hi], st_r.wData, st_r.wStrb);
            RG_WPC: st_nxt.wpCtrl[wrDec.idx] =
              mergeBytes(st_r.wpCtrl[wrDec.idx], st_r.wData, st_r.wStrb) & WP_KEEP;
            RG_WPV: st_nxt.wpVal[wrDec.idx][wrDec.hi] =
              mergeBytes(st_r.wpVal[wrDec.idx][wrDec.hi], st_r.wData, st_r.wStrb);
            default: st_nxt.bresp = RESP_SLVERR;
          endcase
        end
      end
      WS_RESP: begin
        if (bready) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wstate = WS_COLLECT;
        end
      end
    endcase
    // read side: data is captured at the address handshake
    unique case (st_r.rstate)
      RS_IDLE: begin
        if (arvalid && st_r.arready) begin
          st_nxt.rvalid = 1'b1;
          st_nxt.rresp = (rd.rg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
          st_nxt.rstate = RS_DATA;
          unique case (rd.rg)
            RG_DBG: st_nxt.rdata = {31'h0, st_r.dbgEn};
            RG_CSET: st_nxt.rdata = {24'h0, CLAIM_IMPL};
            RG_CCLR: st_nxt.rdata = {24'h0, st_r.claim};
            RG_BPC: st_nxt.rdata = st_r.bpCtrl[rd.idx];
            RG_BPV: st_nxt.rdata = st_r.bpVal[rd.idx][rd.hi];
            RG_WPC: st_nxt.rdata = st_r.wpCtrl[rd.idx];
            RG_WPV: st_nxt.rdata = st_r.wpVal[rd.idx][rd.hi];
            default: st_nxt.rdata = '0;
          endcase
        end
      end
      RS_DATA: begin
        if (rready) begin
          st_nxt.rvalid = 1'b0;
          st_nxt.rstate = RS_IDLE;
        end
      end
    endcase
    // qualifiers to the pipeline lag a control write by one cycle
    for (int i = 0; i < NUM_BP; i++) begin
      st_nxt.bpArmed[i] = st_r.dbgEn & st_r.bpCtrl[i][EN_BIT] & bpPermit[i];
      st_nxt.bpLinked[i] = st_r.bpCtrl[i][MTYPE_LO];
      st_nxt.bpCtxMatch[i] = isContext(bwc_mtype_e'(st_r.bpCtrl[i][MTYPE_LO+:4]));
      st_nxt.bpLinkIdx[4*i+:4] = st_r.bpCtrl[i][LINKIDX_LO+:4];
    end
    for (int i = 0; i < NUM_WP; i++) begin
      // reserved mask or access kind leaves the watchpoint inert
      st_nxt.wpArmed[i] = st_r.dbgEn & wpEnVec[i] & wpPermit[i] & !kindZero[i]
                          & !maskRsvd[i];
      st_nxt.wpLoadArm[i] = st_nxt.wpArmed[i] & st_r.wpCtrl[i][KIND_LO];
      st_nxt.wpStoreArm[i] = st_nxt.wpArmed[i] & st_r.wpCtrl[i][KIND_LO+1];
      st_nxt.wpLinked[i] = st_r.wpCtrl[i][LINK_BIT];
      st_nxt.wpLinkIdx[4*i+:4] = st_r.wpCtrl[i][LINKIDX_LO+:4];
    end
    st_nxt.awready = (st_nxt.wstate == WS_COLLECT) && !st_nxt.awHeld;
    st_nxt.wready = (st_nxt.wstate == WS_COLLECT) && !st_nxt.wHeld;
    st_nxt.arready = (st_nxt.rstate == RS_IDLE);
    // controls are cleared too, so the qualifiers never carry unknowns
    if (rst) begin
      st_nxt = '0;
      st_nxt.wstate = WS_COLLECT;
      st_nxt.rstate = RS_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign bpArmed = st_r.bpArmed;
  assign bpLinked = st_r.bpLinked;
  assign bpCtxMatch = st_r.bpCtxMatch;
  assign bpLinkIdx = st_r.bpLinkIdx;
  assign wpArmed = st_r.wpArmed;
  assign wpLoadArm = st_r.wpLoadArm;
  assign wpStoreArm = st_r.wpStoreArm;
  assign wpLinked = st_r.wpLinked;
  assign wpLinkIdx = st_r.wpLinkIdx;
  assign claimTags = st_r.claim;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence wrBoth;
    wrFire;
  endsequence
  sequence rdTaken;
    arvalid && st_r.arready;
  endsequence

  a_bp_enable_gate: assert property (1 |=> (st_r.bpArmed & ~$past(bpEnVec)) == '0)
    else $error("breakpoint armed while disabled");
  a_wp_enable_gate: assert property (1 |=> (st_r.wpArmed & ~$past(wpEnVec)) == '0)
    else $error("watchpoint armed while disabled");
  a_wp_kind_rsvd: assert property (1 |=> (st_r.wpArmed & $past(kindZero)) == '0)
    else $error("watchpoint armed with reserved access kind");
  a_wp_mask_rsvd: assert property (1 |=> (st_r.wpArmed & $past(maskRsvd)) == '0)
    else $error("watchpoint armed with reserved mask");
  a_claim_set_only: assert property (1 |=> st_r.claim ==
    (($past(st_r.claim) | $past(claimSetMask)) & ~$past(claimClrMask)))
    else $error("claim tags changed wrongly");
  a_ctrl_rsvd_zero: assert property (bpRsvd == '0 && wpRsvd == '0)
    else $error("reserved control bits not zero");
  a_write_answer: assert property (wrBoth |=> st_r.bvalid && !st_r.awready && !st_r.wready)
    else $error("write response missing");
  a_bresp_hold: assert property (st_r.bvalid && !bready |=> st_r.bvalid && $stable(st_r.bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (rdTaken |=> st_r.rvalid && !st_r.arready)
    else $error("read data missing");
endmodule

// ==== testbench/bwc_core_model.sv ====
module bwc_core_model
  import bwc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] bpArmed,
  input wire logic [3:0] wpArmed,
  output logic curSecure,
  output logic [1:0] curEl
);
  timeunit 1ns;
  timeprecision 1ns;
  int armedCycles;
  // state only moves at clock edges, as the real pipeline does
  initial begin
    curSecure = 1'b0;
    curEl = EL_USER;
    armedCycles = 0;
  end
  // the pipeline only looks at armed qualifiers, never at control fields
  always @(posedge mclk) begin
    if (!rst && (|bpArmed || |wpArmed)) begin
      armedCycles <= armedCycles + 1;
    end
  end
  task automatic setState(input logic sec, input logic [1:0] el);
    @(posedge mclk);
    curSecure <= sec;
    curEl <= el;
  endtask
endmodule

// ==== testbench/tb.sv ====
module tb
  import bwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, curSecure;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, wpArmed, wpLoadArm, wpStoreArm, wpLinked;
  logic [1:0] bresp, rresp, curEl;
  logic [5:0] bpArmed, bpLinked, bpCtxMatch;
  logic [23:0] bpLinkIdx;
  logic [15:0] wpLinkIdx;
  logic [7:0] claimTags;
  logic [11:0] valAddr [4] = '{12'h430, 12'h434, 12'h830, 12'h834};
  int errCount = 0;
  int nCompared = 0;

  bwc_top u_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .curSecure(curSecure), .curEl(curEl), .bpArmed(bpArmed), .bpLinked(bpLinked),
    .bpCtxMatch(bpCtxMatch), .bpLinkIdx(bpLinkIdx), .wpArmed(wpArmed),
    .wpLoadArm(wpLoadArm), .wpStoreArm(wpStoreArm), .wpLinked(wpLinked),
    .wpLinkIdx(wpLinkIdx), .claimTags(claimTags));

  bwc_core_model u_core (.mclk(mclk), .rst(rst), .bpArmed(bpArmed), .wpArmed(wpArmed),
    .curSecure(curSecure), .curEl(curEl));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hung(input string what);
    errCount++;
    $display("wrong value %s expected handshake seen none", what);
    wrapUp();
  endtask

  // sample at the falling edge so registered outputs are settled, act on the rising one
  task automatic busWrite(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awHit, wHit, bHit, bSeen;
    logic [1:0] r;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge mclk);
      awHit = awvalid && awready;
      wHit = wvalid && wready;
      bSeen = bvalid;
      bHit = bSeen && bready;
      r = bresp;
      @(posedge mclk);
      if (awHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      if (bHit) begin
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
        return;
      end
      // ready trails the response by a cycle, so it must hold through a stall
      if (bSeen) bready <= 1'b1;
    end
    hung("bvalid");
  endtask

  task automatic busRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic arHit, rHit;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge mclk);
      arHit = arvalid && arready;
      rHit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (arHit) arvalid <= 1'b0;
      if (rHit) begin
        rready <= 1'b0;
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
        return;
      end
    end
    hung("rvalid");
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  function automatic logic [31:0] bpc(input logic [3:0] t, input logic [3:0] linked_index,
    input logic [1:0] sec, input logic higher_level_ctrl, input logic [3:0] byte_lane_select, input logic [1:0] bp_privilege_ctrl,
    input logic en);
    return {8'h0, t, linked_index, sec, higher_level_ctrl, 4'h0, byte_lane_select, 2'h0, bp_privilege_ctrl, en};
  endfunction

  function automatic logic [31:0] wpc(input logic [4:0] m, input logic lk,
    input logic [3:0] linked_index, input logic [1:0] sec, input logic [1:0] kind, input logic en);
    return {3'h0, m, 3'h0, lk, linked_index, sec, 1'b0, 8'hff, kind, 2'b01, en};
  endfunction

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    settle();
    busRead(OFF_CLAIM_SET, 32'h000000ff, RESP_OKAY);
    busRead(OFF_CLAIM_CLR, 32'h0, RESP_OKAY);
    busRead(12'h468, 32'h0, RESP_SLVERR);
    busWrite(12'h848, 32'h1, RESP_SLVERR);
    busRead(12'h848, 32'h0, RESP_SLVERR);
    for (int n = 0; n < 6; n++) begin
      busWrite(12'h408 + 12'(16 * n), 32'hffffffff, RESP_OKAY);
      busRead(12'h408 + 12'(16 * n), BP_CTX_AWARE[n] ? 32'h00bfe1e7 : 32'h001fe1e7,
        RESP_OKAY);
    end
    for (int n = 0; n < 4; n++) begin
      busWrite(12'h808 + 12'(16 * n), 32'hffffffff, RESP_OKAY);
      busRead(12'h808 + 12'(16 * n), 32'h1f1fffff, RESP_OKAY);
    end
    busWrite(OFF_DBG_CTRL, 32'h1, RESP_OKAY);
    settle();
    chk("bpArmed all", 32'h3f, {26'h0, bpArmed});
    chk("wpArmed all", 32'hf, {28'h0, wpArmed});
    foreach (valAddr[i]) begin
      busWrite(valAddr[i], 32'h5a5a0000 ^ 32'(i), RESP_OKAY);
    end
    foreach (valAddr[i]) begin
      busRead(valAddr[i], 32'h5a5a0000 ^ 32'(i), RESP_OKAY);
    end
    // partial strobes touch only the enabled bytes of a value word
    @(posedge mclk);
    wstrb <= 4'h6;
    busWrite(valAddr[0], 32'hffffffff, RESP_OKAY);
    @(posedge mclk);
    wstrb <= 4'hf;
    busRead(valAddr[0], 32'h5affff00, RESP_OKAY);
    for (int t = 0; t < 16; t++) begin
      busWrite(12'h458, bpc(4'(t), 4'(t), 2'b00, 1'b1, 4'hf, 2'b11, 1'b1), RESP_OKAY);
      busRead(12'h458, bpc(4'(t) & 4'hb, 4'(t), 2'b00, 1'b1, 4'hf, 2'b11, 1'b1),
        RESP_OKAY);
      settle();
      chk("bpLinked", 32'(t & 1), {31'h0, bpLinked[5]});
      chk("bpCtxMatch", 32'((t >> 3 | t >> 1) & 1), {31'h0, bpCtxMatch[5]});
      chk("bpLinkIdx", 32'(t), {28'h0, bpLinkIdx[23:20]});
    end
    busWrite(12'h408, bpc(4'h0, 4'h0, 2'b01, 1'b1, 4'h3, 2'b10, 1'b1), RESP_OKAY);
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 4; e++) begin
        u_core.setState(1'(s), 2'(e));
        settle();
        chk("bpArmed0", 32'(s == 0 && (e == 0 || e == 2)), {31'h0, bpArmed[0]});
      end
    end
    // a permitted state, so only the enable bit can hold the breakpoint off
    u_core.setState(1'b0, EL_USER);
    busWrite(12'h408, bpc(4'h0, 4'h0, 2'b00, 1'b1, 4'hc, 2'b11, 1'b0), RESP_OKAY);
    settle();
    chk("bpArmed0 off", 32'h0, {31'h0, bpArmed[0]});
    for (int k = 0; k < 4; k++) begin
      u_core.setState(1'(k != 3), EL_KERNEL);
      busWrite(12'h808, wpc(5'h0, 1'(k), 4'(k + 4), 2'b10, 2'(k), 1'b1), RESP_OKAY);
      settle();
      chk("wpArmed0", 32'(k == 1 || k == 2), {31'h0, wpArmed[0]});
      chk("wpLoadArm0", 32'(k == 1), {31'h0, wpLoadArm[0]});
      chk("wpStoreArm0", 32'(k == 2), {31'h0, wpStoreArm[0]});
      chk("wpLinked0", 32'(k & 1), {31'h0, wpLinked[0]});
      chk("wpLinkIdx0", 32'(k + 4), {28'h0, wpLinkIdx[3:0]});
    end
    u_core.setState(1'b1, EL_KERNEL);
    for (int m = 0; m < 5; m++) begin
      busWrite(12'h808, wpc(5'(m == 4 ? 31 : m), 1'b0, 4'h0, 2'b00, 2'b11, 1'b1),
        RESP_OKAY);
      settle();
      chk("wpArmed mask", 32'(m != 1 && m != 2), {31'h0, wpArmed[0]});
    end
    busWrite(12'h808, wpc(5'h0, 1'b0, 4'h0, 2'b00, 2'b11, 1'b0), RESP_OKAY);
    settle();
    chk("wpArmed0 off", 32'h0, {31'h0, wpArmed[0]});
    busWrite(OFF_CLAIM_SET, 32'h00000005, RESP_OKAY);
    busWrite(OFF_CLAIM_SET, 32'hffffff0a, RESP_OKAY);
    settle();
    chk("claimTags", 32'h0f, {24'h0, claimTags});
    busWrite(OFF_CLAIM_CLR, 32'h00000001, RESP_OKAY);
    busRead(OFF_CLAIM_CLR, 32'h0000000e, RESP_OKAY);
    chk("armedCycles", 32'h1, 32'(u_core.armedCycles > 0));
    wrapUp();
  end
endmodule
